// file: logic/usrx_baud_gen.v
// Baud rate generator: prescaler plus free-running 8-bit down counter.
// Assumes divisor writes arrive as a one-cycle pulse from the register file.
`timescale 1ns/10ps
`default_nettype none
`include "usrx_regs.vh"
module usrx_baud_gen (
    input  wire       clk_i,
    input  wire       reset_i,
    input  wire [7:0] divisor_i,
    input  wire       div_wr_i,
    input  wire       sync_i,
    input  wire       high_speed_i,
    output wire       tick_o
);
    reg  [7:0] pre_q;
    reg  [7:0] cnt_q;
    wire [7:0] pre_max;
    wire       pre_end;

    // Sync ignores the speed bit; async picks 16x or 64x overall
    assign pre_max = sync_i ? `USRX_PRE_SYNC :
                     (high_speed_i ? `USRX_PRE_ASYNC_HI : `USRX_PRE_ASYNC_LO);
    assign pre_end = (pre_q >= pre_max);
    assign tick_o  = pre_end && (cnt_q == 8'h00);

    always @(posedge clk_i) begin
        if (reset_i || div_wr_i) begin
            pre_q <= 8'h00;
            cnt_q <= divisor_i;
        end else if (pre_end) begin
            pre_q <= 8'h00;
            cnt_q <= (cnt_q == 8'h00) ? divisor_i : cnt_q - 8'h01;
        end else begin
            pre_q <= pre_q + 8'h01;
        end
    end
endmodule // usrx_baud_gen
`default_nettype wire

// file: logic/usrx_regs.vh
// Register map, field positions and timing constants of the serial receive/baud block.
// Assumes an APB slave with 32-bit data, one register per byte address, three of seven not word-aligned.
// Summary of operation
// - Nine-bit select chooses 9-bit or 8-bit reception; extra bit lands in ninth-bit field.
// - Framing flag in bit 2 reflects last stored character; updated only when the next byte is stored.
// - One dedicated 8-bit baud generator serves asynchronous and synchronous modes.
// - Divisor register sets the period of a free-running 8-bit timer giving bit timing.
// - In asynchronous mode the high-speed select chooses the prescale.
// - In synchronous mode the high-speed select is ignored.
// - Generator timing applies to async and sync master; sync slave uses external clock.
// - Rates: async low Fosc/(64(X+1)), async high Fosc/(16(X+1)), sync Fosc/(4(X+1)).
// - Any write to the divisor register resets the generator timer at once.
`ifndef USRX_REGS_VH
`define USRX_REGS_VH
`define USRX_ADDR_RCS      12'h018
`define USRX_ADDR_TCS      12'h098
`define USRX_ADDR_DIV      12'h099
`define USRX_ADDR_DATA     12'h01A
`define USRX_ADDR_IRQ_ST   12'h100
`define USRX_ADDR_IRQ_MSK  12'h104
`define USRX_ADDR_PINDIR   12'h087
`define USRX_RCS_EN        7
`define USRX_RCS_RX9       6
`define USRX_RCS_SINGLE_RECEIVE_ENABLE      5
`define USRX_RCS_CONTINUOUS_RECEIVE_ENABLE      4
`define USRX_RCS_FRAMING_ERROR_FLAG      2
`define USRX_RCS_OVERRUN_ERROR_FLAG      1
`define USRX_RCS_RX_NINTH_BIT      0
`define USRX_TCS_CSRC      7
`define USRX_TCS_SYNC      4
`define USRX_TCS_HIGH_SPEED_BAUD_SELECT      2
`define USRX_IRQ_RXDONE    0
`define USRX_IRQ_FRAMING_ERROR_FLAG      1
`define USRX_IRQ_OVERRUN_ERROR_FLAG      2
// Prescale minus one: async 16 ticks a bit, sync one tick a clock half
`define USRX_PRE_ASYNC_LO  8'h03
`define USRX_PRE_ASYNC_HI  8'h00
`define USRX_PRE_SYNC      8'h01
`define USRX_OVS_ASYNC     4'h4
`define USRX_RESET_BYTE    8'h00
`endif

// file: logic/usrx_top.v
// Receive control/status, baud generator and receiver of the serial port.
// Assumes an APB master on clk_i; serial pins are asynchronous to clk_i.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "usrx_regs.vh"
module usrx_top (
    input  wire        clk_i,
    input  wire        reset_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    input  wire        rx_dt_i,
    output wire        rx_dt_o,
    output wire        rx_dt_oe_o,
    input  wire        ck_i,
    output wire        ck_o,
    output wire        ck_oe_o,
    output wire        irq_o
);
    localparam ST_IDLE  = 2'd0;
    localparam ST_START = 2'd1;
    localparam ST_DATA  = 2'd2;
    localparam ST_STOP  = 2'd3;

    reg  [7:0] rcs_q;
    reg  [7:0] tcs_q;
    reg  [7:0] div_q;
    reg  [1:0] pindir_q;
    reg  [8:0] data_q;
    reg        full_q;
    reg  [2:0] ist_q;
    reg  [2:0] imsk_q;
    reg  [2:0] dt_sync_q;
    reg  [2:0] ck_sync_q;
    reg        dt_lvl_q;
    reg        dt_fall_q;
    reg        ck_lvl_q;
    reg        ck_out_q;
    reg  [1:0] st_q;
    reg  [3:0] ovs_q;
    reg  [3:0] bit_q;
    reg  [8:0] sh_q;
    reg        done_q;
    reg        done_framing_error_flag_q;

    wire       wr_en;
    wire       rd_en;
    wire       tick;
    wire       port_on;
    wire       sync_mode;
    wire       master;
    wire       rx_enable;
    wire       sample;
    wire [3:0] nbits;
    wire       ck_rise;
    wire       ck_gen_edge;

    function sel;
        input [11:0] a;
        input [11:0] b;
        begin
            sel = (a == b);
        end
    endfunction

    assign wr_en     = psel_i && penable_i && pwrite_i;
    assign rd_en     = psel_i && penable_i && !pwrite_i;
    assign pready_o  = 1'b1;
    assign pslverr_o = 1'b0;

    // Pins serve the port only with enable and both direction bits set
    assign port_on   = rcs_q[`USRX_RCS_EN] && (pindir_q == 2'b11);
    assign sync_mode = tcs_q[`USRX_TCS_SYNC];
    assign master    = sync_mode && tcs_q[`USRX_TCS_CSRC];
    assign rx_enable = port_on && (rcs_q[`USRX_RCS_CONTINUOUS_RECEIVE_ENABLE] ||
                       (master && rcs_q[`USRX_RCS_SINGLE_RECEIVE_ENABLE]));
    assign nbits     = rcs_q[`USRX_RCS_RX9] ? 4'd9 : 4'd8;

    usrx_baud_gen u_brg (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .divisor_i    (wr_en && sel(paddr_i, `USRX_ADDR_DIV) ? pwdata_i[7:0] : div_q),
        .div_wr_i     (wr_en && sel(paddr_i, `USRX_ADDR_DIV)),
        .sync_i       (sync_mode),
        .high_speed_i (tcs_q[`USRX_TCS_HIGH_SPEED_BAUD_SELECT]),
        .tick_o       (tick)
    );

    // Master drives the clock from the generator; slave samples the external clock
    assign ck_gen_edge = master && tick && (st_q == ST_DATA || st_q == ST_STOP);
    assign ck_rise     = master ? (ck_gen_edge && ck_out_q == 1'b0)
                                : (ck_lvl_q == 1'b0 && ck_sync_q[2] && ck_sync_q[1]);
    assign sample      = sync_mode ? ck_rise : (tick && ovs_q == 4'h0);
    assign ck_o        = ck_out_q;
    assign ck_oe_o     = port_on && master;
    assign rx_dt_o     = 1'b0;
    assign rx_dt_oe_o  = 1'b0;
    assign irq_o       = |(ist_q & imsk_q);

    // Pin synchronisers; a level changes once stages two and three agree
    always @(posedge clk_i) begin
        if (reset_i) begin
            dt_sync_q <= 3'b111;
            ck_sync_q <= 3'b000;
            dt_lvl_q  <= 1'b1;
            ck_lvl_q  <= 1'b0;
            dt_fall_q <= 1'b0;
        end else begin
            dt_sync_q <= {dt_sync_q[1:0], rx_dt_i};
            // Start needs a falling edge, so a held-low line gives no phantom frame
            dt_fall_q <= dt_lvl_q && (dt_sync_q[2] == dt_sync_q[1]) && !dt_sync_q[2];
            ck_sync_q <= {ck_sync_q[1:0], ck_i};
            if (dt_sync_q[2] == dt_sync_q[1]) begin
                dt_lvl_q <= dt_sync_q[2];
            end
            if (ck_sync_q[2] == ck_sync_q[1]) begin
                ck_lvl_q <= ck_sync_q[2];
            end
        end
    end

    // Receiver: async samples every 16th over-tick, first five ticks after start, sync uses clock edges
    always @(posedge clk_i) begin
        if (reset_i || !rx_enable) begin
            st_q        <= ST_IDLE;
            ovs_q       <= 4'h0;
            bit_q       <= 4'h0;
            sh_q        <= 9'h000;
            done_q      <= 1'b0;
            done_framing_error_flag_q <= 1'b0;
            ck_out_q    <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (ck_gen_edge) begin
                ck_out_q <= ~ck_out_q;
            end
            if (!sync_mode && tick) begin
                ovs_q <= ovs_q - 4'h1;
            end
            case (st_q)
                ST_IDLE: begin
                    bit_q <= 4'h0;
                    if (sync_mode) begin
                        st_q <= ST_DATA;
                    end else if (dt_fall_q) begin
                        st_q  <= ST_START;
                        ovs_q <= `USRX_OVS_ASYNC;
                    end
                end
                ST_START: begin
                    if (sample) begin
                        st_q <= dt_lvl_q ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (sample) begin
                        sh_q  <= {dt_lvl_q, sh_q[8:1]};
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == nbits - 4'h1) begin
                            if (sync_mode && !master) begin
                                done_q      <= 1'b1;
                                done_framing_error_flag_q <= 1'b0;
                                st_q        <= ST_IDLE;
                            end else begin
                                // Master still owes the falling clock edge
                                st_q <= ST_STOP;
                            end
                        end
                    end
                end
                ST_STOP: begin
                    if (master) begin
                        if (ck_gen_edge) begin
                            done_q      <= 1'b1;
                            done_framing_error_flag_q <= 1'b0;
                            st_q        <= ST_IDLE;
                        end
                    end else if (sample) begin
                        done_q      <= 1'b1;
                        done_framing_error_flag_q <= !dt_lvl_q;
                        st_q        <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Register file and receive holding word
    always @(posedge clk_i) begin
        if (reset_i) begin
            rcs_q    <= `USRX_RESET_BYTE;
            tcs_q    <= `USRX_RESET_BYTE;
            div_q    <= `USRX_RESET_BYTE;
            pindir_q <= 2'b00;
            data_q   <= 9'h000;
            full_q   <= 1'b0;
            ist_q    <= 3'b000;
            imsk_q   <= 3'b000;
        end else begin
            if (wr_en && sel(paddr_i, `USRX_ADDR_RCS)) begin
                rcs_q[7:4] <= pwdata_i[7:4];
                if (!pwdata_i[`USRX_RCS_CONTINUOUS_RECEIVE_ENABLE]) begin
                    rcs_q[`USRX_RCS_OVERRUN_ERROR_FLAG] <= 1'b0;
                end
            end
            if (wr_en && sel(paddr_i, `USRX_ADDR_TCS)) begin
                tcs_q <= pwdata_i[7:0];
            end
            if (wr_en && sel(paddr_i, `USRX_ADDR_DIV)) begin
                div_q <= pwdata_i[7:0];
            end
            if (wr_en && sel(paddr_i, `USRX_ADDR_PINDIR)) begin
                pindir_q <= pwdata_i[7:6];
            end
            if (wr_en && sel(paddr_i, `USRX_ADDR_IRQ_MSK)) begin
                imsk_q <= pwdata_i[2:0];
            end
            if (rd_en && sel(paddr_i, `USRX_ADDR_DATA)) begin
                full_q <= 1'b0;
            end
            if (rd_en && sel(paddr_i, `USRX_ADDR_IRQ_ST)) begin
                ist_q <= 3'b000;
            end
            // New character beats a same-cycle clear or read
            if (done_q) begin
                if (full_q && !(rd_en && sel(paddr_i, `USRX_ADDR_DATA))) begin
                    rcs_q[`USRX_RCS_OVERRUN_ERROR_FLAG] <= 1'b1;
                    ist_q[`USRX_IRQ_OVERRUN_ERROR_FLAG] <= 1'b1;
                end else begin
                    full_q <= 1'b1;
                    data_q <= rcs_q[`USRX_RCS_RX9] ? sh_q : {1'b0, sh_q[8:1]};
                    rcs_q[`USRX_RCS_RX_NINTH_BIT] <= rcs_q[`USRX_RCS_RX9] && sh_q[8];
                    rcs_q[`USRX_RCS_FRAMING_ERROR_FLAG] <= done_framing_error_flag_q;
                    ist_q[`USRX_IRQ_RXDONE] <= 1'b1;
                    if (done_framing_error_flag_q) begin
                        ist_q[`USRX_IRQ_FRAMING_ERROR_FLAG] <= 1'b1;
                    end
                end
                if (!rcs_q[`USRX_RCS_CONTINUOUS_RECEIVE_ENABLE]) begin
                    rcs_q[`USRX_RCS_SINGLE_RECEIVE_ENABLE] <= 1'b0;
                end
            end
        end
    end

    always @* begin
        prdata_o = 32'h0000_0000;
        if (rd_en) begin
            case (paddr_i)
                `USRX_ADDR_RCS:     prdata_o = {24'h00_0000, rcs_q[7:4], 1'b0, rcs_q[2:0]};
                `USRX_ADDR_TCS:     prdata_o = {24'h00_0000, tcs_q};
                `USRX_ADDR_DIV:     prdata_o = {24'h00_0000, div_q};
                `USRX_ADDR_DATA:    prdata_o = {23'h00_0000, data_q};
                `USRX_ADDR_PINDIR:  prdata_o = {24'h00_0000, pindir_q, 6'h00};
                `USRX_ADDR_IRQ_ST:  prdata_o = {29'h0000_0000, ist_q};
                `USRX_ADDR_IRQ_MSK: prdata_o = {29'h0000_0000, imsk_q};
                default:            prdata_o = 32'h0000_0000;
            endcase
        end
    end
endmodule // usrx_top
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for usrx_top with a serial peer.
// Assumes the register header and a 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "usrx_regs.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_fail++; \
    $display("unexpected %s expected %h seen %h", n, e, s); end end
module testbench;
    logic        clk_i;
    logic        reset_i = 1'b1;
    logic        psel    = 1'b0;
    logic        pen     = 1'b0;
    logic        pwr     = 1'b0;
    logic [11:0] addr    = 12'h000;
    logic [31:0] wdata   = 32'h0000_0000;
    logic [31:0] v;
    wire  [31:0] rdata;
    wire         ready, err, rxo, rxoe, cko, ckoe, irq, rx, ck;
    int          n_fail  = 0;
    int          checks  = 0;
    usrx_top u_usrx_top (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdata), .prdata_o(rdata), .pready_o(ready),
        .pslverr_o(err), .rx_dt_i(rx), .rx_dt_o(rxo), .rx_dt_oe_o(rxoe), .ck_i(ck),
        .ck_o(cko), .ck_oe_o(ckoe), .irq_o(irq));
    usrx_peer u_usrx_peer (.clk_i(clk_i), .rx_o(rx), .ck_o(ck));
    task automatic acc(input logic wr, input logic [11:0] a, input logic [8:0] d);
        @(posedge clk_i);
        psel  <= 1'b1;
        pwr   <= wr;
        addr  <= a;
        wdata <= {23'h00_0000, d};
        @(posedge clk_i);
        pen <= 1'b1;
        @(posedge clk_i);
        while (ready !== 1'b1) @(posedge clk_i);
        v = rdata;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(negedge clk_i);
    endtask
    task automatic w(input logic [11:0] a, input logic [8:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic er(input logic [11:0] a, input logic [8:0] e);
        acc(1'b0, a, 9'h000);
        `CHK("read data", e, v[8:0])
    endtask
    task automatic wirq;
        int k;
        for (k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge clk_i);
        @(negedge clk_i);
        `CHK("irq", 1'b1, irq)
    endtask
    task automatic half(input int e);
        int k;
        k = 0;
        @(posedge cko);
        @(negedge clk_i);
        while (cko === 1'b1 && k < 600) begin
            k++;
            @(negedge clk_i);
        end
        `CHK("clock half", e, k)
    endtask
    task automatic snd(input logic [8:0] d, input int nb, input logic stp);
        u_usrx_peer.send(d, nb, stp, 64);
        wirq;
    endtask
    task automatic end_sim;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #200000;
        n_fail++;
        end_sim;
    end
    task automatic t_reset;
        er(`USRX_ADDR_RCS, 9'h000);
        er(`USRX_ADDR_TCS, 9'h000);
        er(`USRX_ADDR_DIV, 9'h000);
        er(12'h200, 9'h000);
        $display("reset test done");
    endtask
    task automatic t_async;
        w(`USRX_ADDR_PINDIR, 9'h0C0);
        w(`USRX_ADDR_IRQ_MSK, 9'h007);
        w(`USRX_ADDR_TCS, 9'h004);
        w(`USRX_ADDR_DIV, 9'h003);
        w(`USRX_ADDR_RCS, 9'h090);
        snd(9'h0A5, 8, 1'b1);
        er(`USRX_ADDR_DATA, 9'h0A5);
        w(`USRX_ADDR_IRQ_MSK, 9'h000);
        `CHK("irq masked", 1'b0, irq)
        w(`USRX_ADDR_IRQ_MSK, 9'h007);
        `CHK("irq unmasked", 1'b1, irq)
        er(`USRX_ADDR_IRQ_ST, 9'h001);
        `CHK("irq cleared", 1'b0, irq)
        $display("async test done");
    endtask
    task automatic t_framing;
        snd(9'h055, 8, 1'b0);
        er(`USRX_ADDR_RCS, 9'h094);
        er(`USRX_ADDR_DATA, 9'h055);
        er(`USRX_ADDR_IRQ_ST, 9'h003);
        snd(9'h033, 8, 1'b1);
        er(`USRX_ADDR_RCS, 9'h090);
        er(`USRX_ADDR_DATA, 9'h033);
        er(`USRX_ADDR_IRQ_ST, 9'h001);
        $display("framing test done");
    endtask
    task automatic t_overrun;
        snd(9'h011, 8, 1'b1);
        snd(9'h022, 8, 1'b1);
        er(`USRX_ADDR_RCS, 9'h092);
        er(`USRX_ADDR_DATA, 9'h011);
        w(`USRX_ADDR_RCS, 9'h080);
        er(`USRX_ADDR_RCS, 9'h080);
        er(`USRX_ADDR_IRQ_ST, 9'h005);
        $display("overrun test done");
    endtask
    task automatic t_nine;
        w(`USRX_ADDR_RCS, 9'h0D0);
        snd(9'h13C, 9, 1'b1);
        er(`USRX_ADDR_RCS, 9'h0D1);
        er(`USRX_ADDR_DATA, 9'h13C);
        er(`USRX_ADDR_IRQ_ST, 9'h001);
        $display("nine bit test done");
    endtask
    task automatic t_low;
        w(`USRX_ADDR_RCS, 9'h090);
        w(`USRX_ADDR_TCS, 9'h000);
        w(`USRX_ADDR_DIV, 9'h000);
        snd(9'h05A, 8, 1'b1);
        er(`USRX_ADDR_DATA, 9'h05A);
        er(`USRX_ADDR_IRQ_ST, 9'h001);
        $display("low speed test done");
    endtask
    task automatic t_sync;
        w(`USRX_ADDR_TCS, 9'h094);
        w(`USRX_ADDR_DIV, 9'h001);
        w(`USRX_ADDR_RCS, 9'h0A0);
        `CHK("clock enable", 1'b1, ckoe)
        half(4);
        wirq;
        er(`USRX_ADDR_RCS, 9'h080);
        er(`USRX_ADDR_DATA, 9'h0FF);
        w(`USRX_ADDR_RCS, 9'h090);
        w(`USRX_ADDR_DIV, 9'h007);
        half(16);
        w(`USRX_ADDR_TCS, 9'h000);
        `CHK("clock enable off", 1'b0, ckoe)
        $display("sync test done");
    endtask
    task automatic t_slave;
        // Stop receiving and drain what the free-running receives left behind
        w(`USRX_ADDR_RCS, 9'h080);
        acc(1'b0, `USRX_ADDR_DATA, 9'h000);
        acc(1'b0, `USRX_ADDR_IRQ_ST, 9'h000);
        w(`USRX_ADDR_TCS, 9'h010);
        `CHK("slave clock enable", 1'b0, ckoe)
        w(`USRX_ADDR_RCS, 9'h090);
        u_usrx_peer.clk_send(9'h096, 8, 8);
        wirq;
        er(`USRX_ADDR_DATA, 9'h096);
        er(`USRX_ADDR_IRQ_ST, 9'h001);
        $display("slave test done");
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset;
        t_async;
        t_framing;
        t_overrun;
        t_nine;
        t_low;
        t_sync;
        t_slave;
        end_sim;
    end
endmodule // testbench
`default_nettype wire

// file: tb/usrx_monitor.sv
// Port checker for usrx_top.
// Assumes zero-wait APB and the register header.
`timescale 1ns/10ps
`default_nettype none
`include "usrx_regs.vh"
module usrx_monitor (
    input wire        clk_i,
    input wire        reset_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire        pready_o,
    input wire        pslverr_o,
    input wire        rx_dt_o,
    input wire        rx_dt_oe_o,
    input wire        ck_o,
    input wire        ck_oe_o,
    input wire        irq_o
);
    wire       acc = psel_i & penable_i;
    wire       wr  = acc & pwrite_i;
    wire       rd  = acc & !pwrite_i;
    reg  [7:0] div_q;
    reg  [7:0] tcs_q;
    reg        en_q;
    reg        seen_q;
    reg  [9:0] cnt_q;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // Any write restarts the count, since mode or divisor may move
    always @(posedge clk_i) begin
        if (reset_i || wr || !ck_oe_o) begin
            cnt_q  <= 10'h001;
            seen_q <= 1'b0;
        end else if (ck_o != $past(ck_o)) begin
            cnt_q  <= 10'h001;
            seen_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 10'h001;
        end
        if (reset_i) begin
            div_q <= 8'h00;
            tcs_q <= 8'h00;
            en_q  <= 1'b0;
        end else if (wr && paddr_i == `USRX_ADDR_DIV) begin
            div_q <= pwdata_i[7:0];
        end else if (wr && paddr_i == `USRX_ADDR_TCS) begin
            tcs_q <= pwdata_i[7:0];
        end else if (wr && paddr_i == `USRX_ADDR_RCS) begin
            en_q <= pwdata_i[`USRX_RCS_EN];
        end
    end
    a_ready_high: assert property (pready_o) else $error("pready low");
    a_no_slverr: assert property (!pslverr_o) else $error("pslverr high");
    a_rdata_idle: assert property (!acc |-> prdata_o == 32'h0000_0000)
        else $error("read data outside access");
    a_rdata_width: assert property (rd |-> prdata_o[31:9] == 23'h00_0000)
        else $error("read data upper bits set");
    a_rcs_unused: assert property (rd && paddr_i == `USRX_ADDR_RCS |->
        !prdata_o[8] && !prdata_o[3]) else $error("control unused bit set");
    a_rx_silent: assert property (!rx_dt_oe_o && !rx_dt_o) else $error("data pin driven");
    a_ck_oe_mode: assert property (ck_oe_o ==
        (tcs_q[`USRX_TCS_CSRC] & tcs_q[`USRX_TCS_SYNC] & en_q)) else $error("clock enable");
    a_ck_half: assert property (ck_oe_o && seen_q && $changed(ck_o) |->
        cnt_q == {1'b0, div_q, 1'b0} + 10'h002) else $error("clock half period");
    a_irq_masked: assert property (wr && paddr_i == `USRX_ADDR_IRQ_MSK &&
        pwdata_i[2:0] == 3'h0 |=> !irq_o) else $error("irq with mask clear");
endmodule // usrx_monitor
bind usrx_top usrx_monitor u_usrx_monitor (.clk_i(clk_i), .reset_i(reset_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .rx_dt_o(rx_dt_o), .rx_dt_oe_o(rx_dt_oe_o), .ck_o(ck_o), .ck_oe_o(ck_oe_o),
    .irq_o(irq_o));
`default_nettype wire

// file: tb/usrx_peer.sv
// Serial peer model on the receive data and clock pins.
// Assumes the bench gives bit and clock half lengths in clocks.
`timescale 1ns/10ps
`default_nettype none
module usrx_peer (
    input  wire  clk_i,
    output logic rx_o,
    output logic ck_o
);
    // Idle high as with a pull-up; clock idles low between frames
    initial rx_o = 1'b1;
    initial ck_o = 1'b0;
    // Slave clocking: data moves with the falling edge, rising edge samples
    task automatic clk_send(input logic [8:0] d, input int nb, input int h);
        for (int i = 0; i < nb; i++) begin
            @(posedge clk_i);
            rx_o <= d[i];
            ck_o <= 1'b0;
            repeat (h) @(posedge clk_i);
            ck_o <= 1'b1;
            repeat (h - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        ck_o <= 1'b0;
        rx_o <= 1'b1;
        repeat (h) @(posedge clk_i);
    endtask
    // Start, data LSB first, stop, then one idle bit
    task automatic send(input logic [8:0] d, input int nb, input logic stp, input int len);
        for (int i = -1; i <= nb; i++) begin
            @(posedge clk_i);
            rx_o <= (i < 0) ? 1'b0 : (i == nb) ? stp : d[i];
            repeat (len - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        rx_o <= 1'b1;
        repeat (len) @(posedge clk_i);
    endtask
endmodule // usrx_peer
`default_nettype wire
